//--- design/irqpnd_pkg.sv
// package of register offsets, bit positions, levels and reset values for the pending block
package irqpnd_pkg;
    // register byte offsets on the apb bus
    localparam logic [11:0] PEND_OFFSET = 12'h000; // pending flags, read only plus w1c
    localparam logic [11:0] MASK_OFFSET = 12'h004; // mask register
    localparam logic [11:0] STAT_OFFSET = 12'h008; // status = pending and not masked
    localparam logic [11:0] CTRL_OFFSET = 12'h00C; // edge selects and pen polarity
    localparam logic [11:0] EMUS_OFFSET = 12'h010; // emulation status register
    localparam logic [11:0] KEYCLR_OFFSET = 12'h014; // port d keyboard-type clear register
    // pending register bit positions
    localparam int BIT_EMU = 23;
    localparam int BIT_SAM = 22;
    localparam int BIT_PEN = 20;
    localparam int BIT_REQ6 = 19;
    localparam int BIT_REQ3 = 18;
    localparam int BIT_REQ2 = 17;
    localparam int BIT_REQ1 = 16;
    localparam int BIT_KT0 = 8;
    localparam int BIT_PWM = 7;
    localparam int BIT_KEY = 6;
    localparam int BIT_RTC = 4;
    localparam int BIT_WDOG = 3;
    localparam int BIT_UART = 2;
    localparam int BIT_TIMER = 1;
    localparam int BIT_SERP = 0;
    // number of keyboard-type inputs and key inputs
    localparam int KT_COUNT = 4;
    localparam int KEY_COUNT = 8;
    // control register bit positions
    localparam int CTL_EDGE1 = 0;
    localparam int CTL_EDGE2 = 1;
    localparam int CTL_EDGE3 = 2;
    localparam int CTL_EDGE5 = 3;
    localparam int CTL_EDGE6 = 4;
    localparam int CTL_KTEDGE = 8;
    localparam int CTL_PEN_POLARITY_SELECT = 12;
    // emulation status bits
    localparam int EMU_BRK0 = 0;
    localparam int EMU_BRK1 = 1;
    localparam int EMU_EXT = 2;
    // priority levels
    localparam logic [2:0] LVL_NONE = 3'h0;
    localparam logic [2:0] LVL_1 = 3'h1;
    localparam logic [2:0] LVL_2 = 3'h2;
    localparam logic [2:0] LVL_3 = 3'h3;
    localparam logic [2:0] LVL_4 = 3'h4;
    localparam logic [2:0] LVL_5 = 3'h5;
    localparam logic [2:0] LVL_6 = 3'h6;
    localparam logic [2:0] LVL_7 = 3'h7;
    // reset values and masks
    localparam logic [31:0] MASK_RESET = 32'hFFFFFFFF;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [31:0] ZERO32 = 32'h00000000;
    localparam logic [31:0] CTRL_WMASK = 32'h00001F1F;
    localparam logic [2:0] EMU_NONE = 3'h0;
    localparam logic [3:0] KT_NONE = 4'h0;
endpackage : irqpnd_pkg

//--- design/irqpnd_top.sv
// interrupt pending-flag logic with apb register access and priority output
//
// Behaviour
// - emulator flag requests level seven
// - emulator flag ORs two breakpoints, external
// - external emulator request latches on falling edge
// - emulation status bit cleared by writing one
// - sampling timer count sets its flag
// - request pins map to own levels
// - level-sensitive pin flag follows pin
// - edge pin flag cleared by one, zero ignored
// - keyboard-type flags level four, portd clear
// - modulator rollover sets flag, level six
// - keyboard flag level four
// - rtc, watchdog, uart flags level four
// - timer event flag level six
// - serial flag level four, cleared at source
// - eight key inputs ORed together
// - key inputs share keyboard-type, request pins
// - key press wakes sleeping core
// - pen pin level five, active-going edge or level
// - pen polarity from control register bit
// - masked sources still set pending
// - pending register read-only except w1c
`timescale 1ns/1ps
module irqpnd_top
(
    input wire logic clock,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // emulation unit breakpoints and external active-low request
    input wire logic emuBreak0,
    input wire logic emuBreak1,
    input wire logic externalEmulatorRequestN,
    // peripheral request levels
    input wire logic samplingTimerEvent,
    input wire logic pwmRollover,
    input wire logic rtcRequest,
    input wire logic watchdogRequest,
    input wire logic uartRequest,
    input wire logic timerEvent,
    input wire logic serialDone,
    // external request pins, active low except the pen pin, whose sense is selectable
    input wire logic externalRequestPin1N,
    input wire logic externalRequestPin2N,
    input wire logic externalRequestPin3N,
    input wire logic externalRequestPin6N,
    input wire logic penRequestPin,
    input wire logic [3:0] keyboardTypeInputN,
    // outputs to the core
    output logic [2:0] priorityLevel,
    output logic wakeCore,
    output logic [31:0] pendingFlags
);
    // registers
    // every flag and latch below is a
    // plain flip-flop; the block has no
    // counters, no buffers and no state
    // machine, only the mask and control words, sticky bits, edge
    // detectors, output registers and the bus answer
    logic [31:0] mask_q; // mask register
    logic [31:0] ctrl_q; // control register
    logic [2:0] emuStat_q; // emulation status bits
    logic emuReqPrev_q; // previous external emulator request level
    logic [4:0] pinPrev_q; // previous levels of the five request pins
    logic [4:0] pinEdge_q; // latched edge flags of the five request pins
    logic [3:0] ktPrev_q; // previous keyboard-type levels
    logic [3:0] ktEdge_q; // latched keyboard-type edge flags
    logic [31:0] pend_q; // registered pending view
    logic [31:0] pend_d; // next pending view
    logic [2:0] lvl_d; // next priority level
    logic [4:0] pinActive; // request pins active high
    logic [4:0] pinEdgeSel; // edge select of each request pin
    logic [3:0] ktActive; // keyboard-type inputs active high
    logic [7:0] keyInputs; // key inputs on shared pins
    logic wrEn; // apb write in access phase
    logic rdEn; // apb read in access phase
    logic [31:0] wdata; // write data masked to byte strobes

    // helper functions
    // the strobe expansion and the write
    // decode are shared by every write
    // path, so each register sees the
    // same byte gating and address match
    // byte-strobe expansion used for every register write
    function automatic logic [31:0] strobeMask(input logic [3:0] s);
        strobeMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strobeMask

    // decode an offset as a hit for a write
    function automatic logic hitWrite(input logic [11:0] a, input logic [11:0] off,
                                      input logic en);
        hitWrite = en && (a == off);
    endfunction : hitWrite

    // bus qualifiers
    // writes commit at the edge that
    // closes the access phase, when
    // psel, penable and pwrite are high;
    // no wait states are ever inserted
    // bus qualifiers; slave answers in the first access cycle
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    assign wdata = pwdata & strobeMask(pstrb);

    // pin polarity
    // request pins arrive active low and
    // are turned active high here so the
    // edge detectors and the level view
    // share one sense; the pen pin alone
    // takes its sense from the control
    // register, low active out of reset
    // pins 1,2,3,5,6 as active-high requests; pen polarity selectable
    assign pinActive[0] = !externalRequestPin1N;
    assign pinActive[1] = !externalRequestPin2N;
    assign pinActive[2] = !externalRequestPin3N;
    assign pinActive[3] = penRequestPin ^ !ctrl_q[irqpnd_pkg::CTL_PEN_POLARITY_SELECT];
    assign pinActive[4] = !externalRequestPin6N;
    assign pinEdgeSel = {ctrl_q[irqpnd_pkg::CTL_EDGE6], ctrl_q[irqpnd_pkg::CTL_EDGE5],
                         ctrl_q[irqpnd_pkg::CTL_EDGE3], ctrl_q[irqpnd_pkg::CTL_EDGE2],
                         ctrl_q[irqpnd_pkg::CTL_EDGE1]};
    assign ktActive = ~keyboardTypeInputN;
    // key inputs share the keyboard-type and request pins 1,2,3,6
    assign keyInputs = {pinActive[4], pinActive[2], pinActive[1], pinActive[0], ktActive};

    // mask and control registers
    // the mask comes up all ones so that
    // no source raises the priority level before
    // software has set the block up;
    // control bits without a meaning are
    // dropped on write and read as zero
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mask_q <= irqpnd_pkg::MASK_RESET;
            ctrl_q <= irqpnd_pkg::CTRL_RESET;
        end
        else
        begin
            // write mask register
            if (hitWrite(paddr, irqpnd_pkg::MASK_OFFSET, wrEn))
                mask_q <= (mask_q & ~strobeMask(pstrb)) | wdata;
            // write control register, only defined bits
            if (hitWrite(paddr, irqpnd_pkg::CTRL_OFFSET, wrEn))
                ctrl_q <= ((ctrl_q & ~strobeMask(pstrb)) | wdata) & irqpnd_pkg::CTRL_WMASK;
        end
    end

    // emulation status
    // each source keeps its own sticky
    // bit so software can tell them
    // apart before clearing; a request
    // that lands in the same cycle as
    // its clear survives, so none is lost
    // the previous level resets high, the
    // idle level, to avoid a false edge
    // emulation status: falling edge on external request, breakpoints; set wins over clear
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            emuStat_q <= irqpnd_pkg::EMU_NONE;
            emuReqPrev_q <= 1'b1;
        end
        else
        begin
            emuReqPrev_q <= externalEmulatorRequestN;
            for (int i = 0; i < 3; i++)
            begin
                // write one clears the chosen source bit
                if (hitWrite(paddr, irqpnd_pkg::EMUS_OFFSET, wrEn) && wdata[i])
                    emuStat_q[i] <= 1'b0;
            end
            if (emuBreak0)
                emuStat_q[irqpnd_pkg::EMU_BRK0] <= 1'b1;
            if (emuBreak1)
                emuStat_q[irqpnd_pkg::EMU_BRK1] <= 1'b1;
            if (emuReqPrev_q && !externalEmulatorRequestN)
                emuStat_q[irqpnd_pkg::EMU_EXT] <= 1'b1;
        end
    end

    // request pin edge latches
    // a latch only sets while its pin is
    // edge selected; in level mode the
    // pending bit follows the pin and the
    // latch is ignored, so a stale latch
    // left from edge mode must be cleared
    // by software before switching back
    // request pin edge latches, write-one-to-clear on the pending register
    generate
        for (genvar g = 0; g < 5; g++)
        begin : gPin
            localparam int PB = (g == 0) ? irqpnd_pkg::BIT_REQ1 :
                                (g == 1) ? irqpnd_pkg::BIT_REQ2 :
                                (g == 2) ? irqpnd_pkg::BIT_REQ3 :
                                (g == 3) ? irqpnd_pkg::BIT_PEN : irqpnd_pkg::BIT_REQ6;
            always_ff @(posedge clock or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    pinPrev_q[g] <= 1'b0;
                    pinEdge_q[g] <= 1'b0;
                end
                else
                begin
                    pinPrev_q[g] <= pinActive[g];
                    // zero writes leave the flag alone
                    if (hitWrite(paddr, irqpnd_pkg::PEND_OFFSET, wrEn) && wdata[PB])
                        pinEdge_q[g] <= 1'b0;
                    // new edge wins over a clear in the same cycle
                    if (pinEdgeSel[g] && pinActive[g] && !pinPrev_q[g])
                        pinEdge_q[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // keyboard-type edge latches
    // these clear only through their own
    // clear register, never through the
    // pending register; a new edge in the
    // clear cycle wins over the clear
    // keyboard-type edge latches cleared through the port d clear register
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ktPrev_q <= irqpnd_pkg::KT_NONE;
            ktEdge_q <= irqpnd_pkg::KT_NONE;
        end
        else
        begin
            ktPrev_q <= ktActive;
            for (int i = 0; i < irqpnd_pkg::KT_COUNT; i++)
            begin
                if (hitWrite(paddr, irqpnd_pkg::KEYCLR_OFFSET, wrEn) && wdata[i])
                    ktEdge_q[i] <= 1'b0;
                if (ctrl_q[irqpnd_pkg::CTL_KTEDGE + i] && ktActive[i] && !ktPrev_q[i])
                    ktEdge_q[i] <= 1'b1;
            end
        end
    end

    // pending view
    // the mask plays no part here: a
    // masked source still shows pending,
    // and only the status view and the
    // level encoder apply the mask
    // peripheral levels are passed through
    // as held by their sources, which
    // clear them at the source itself
    // assemble the pending view; sources set flags regardless of mask
    always_comb
    begin
        pend_d = irqpnd_pkg::ZERO32; // reserved bits read zero
        pend_d[irqpnd_pkg::BIT_EMU] = |emuStat_q;
        pend_d[irqpnd_pkg::BIT_SAM] = samplingTimerEvent;
        pend_d[irqpnd_pkg::BIT_REQ1] = pinEdgeSel[0] ? pinEdge_q[0] : pinActive[0];
        pend_d[irqpnd_pkg::BIT_REQ2] = pinEdgeSel[1] ? pinEdge_q[1] : pinActive[1];
        pend_d[irqpnd_pkg::BIT_REQ3] = pinEdgeSel[2] ? pinEdge_q[2] : pinActive[2];
        pend_d[irqpnd_pkg::BIT_PEN] = pinEdgeSel[3] ? pinEdge_q[3] : pinActive[3];
        pend_d[irqpnd_pkg::BIT_REQ6] = pinEdgeSel[4] ? pinEdge_q[4] : pinActive[4];
        for (int i = 0; i < irqpnd_pkg::KT_COUNT; i++)
        begin
            pend_d[irqpnd_pkg::BIT_KT0 + i] = ctrl_q[irqpnd_pkg::CTL_KTEDGE + i] ?
                                             ktEdge_q[i] : ktActive[i];
        end
        pend_d[irqpnd_pkg::BIT_PWM] = pwmRollover;
        pend_d[irqpnd_pkg::BIT_KEY] = |keyInputs;
        pend_d[irqpnd_pkg::BIT_RTC] = rtcRequest;
        pend_d[irqpnd_pkg::BIT_WDOG] = watchdogRequest;
        pend_d[irqpnd_pkg::BIT_UART] = uartRequest;
        pend_d[irqpnd_pkg::BIT_TIMER] = timerEvent;
        pend_d[irqpnd_pkg::BIT_SERP] = serialDone;
    end

    // level encoder
    // later tests override earlier ones,
    // so the list runs from the lowest
    // level to the highest and the last
    // matching source sets the result;
    // it reads the registered view so the
    // level lines up with the flags read
    // highest level among pending, unmasked flags from the registered view
    always_comb
    begin
        logic [31:0] act;
        act = pend_q & ~mask_q;
        lvl_d = irqpnd_pkg::LVL_NONE;
        if (act[irqpnd_pkg::BIT_REQ1])
            lvl_d = irqpnd_pkg::LVL_1;
        if (act[irqpnd_pkg::BIT_REQ2])
            lvl_d = irqpnd_pkg::LVL_2;
        if (act[irqpnd_pkg::BIT_REQ3])
            lvl_d = irqpnd_pkg::LVL_3;
        if (act[irqpnd_pkg::BIT_KEY] || act[irqpnd_pkg::BIT_RTC] ||
            act[irqpnd_pkg::BIT_WDOG] || act[irqpnd_pkg::BIT_UART] ||
            act[irqpnd_pkg::BIT_SERP] || (|act[irqpnd_pkg::BIT_KT0 +: 4]))
            lvl_d = irqpnd_pkg::LVL_4;
        if (act[irqpnd_pkg::BIT_PEN])
            lvl_d = irqpnd_pkg::LVL_5;
        if (act[irqpnd_pkg::BIT_REQ6] || act[irqpnd_pkg::BIT_PWM] ||
            act[irqpnd_pkg::BIT_TIMER] || act[irqpnd_pkg::BIT_SAM])
            lvl_d = irqpnd_pkg::LVL_6;
        if (act[irqpnd_pkg::BIT_EMU])
            lvl_d = irqpnd_pkg::LVL_7;
    end

    // output registers
    // all outputs leave from flip-flops;
    // the wake line is the plain or of
    // the key inputs and ignores the mask
    // so a sleeping core always wakes
    // registered outputs: pending view, level and wake
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pend_q <= irqpnd_pkg::ZERO32;
            priorityLevel <= irqpnd_pkg::LVL_NONE;
            wakeCore <= 1'b0;
            pendingFlags <= irqpnd_pkg::ZERO32;
        end
        else
        begin
            pend_q <= pend_d;
            pendingFlags <= pend_d;
            priorityLevel <= lvl_d;
            wakeCore <= |keyInputs;
        end
    end

    // bus answer
    // read data is loaded in the setup
    // cycle and stands for the single
    // access cycle; an unmapped address
    // gets an error and zero data, and a
    // write to it changes nothing
    // apb read path and answer; one-cycle access phase, unmapped reads zero with error
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdata <= irqpnd_pkg::ZERO32;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= irqpnd_pkg::ZERO32;
            if (psel && !penable)
            begin
                case (paddr)
                    irqpnd_pkg::PEND_OFFSET: prdata <= pend_q;
                    irqpnd_pkg::MASK_OFFSET: prdata <= mask_q;
                    irqpnd_pkg::STAT_OFFSET: prdata <= pend_q & ~mask_q;
                    irqpnd_pkg::CTRL_OFFSET: prdata <= ctrl_q;
                    irqpnd_pkg::EMUS_OFFSET: prdata <= {29'h0, emuStat_q};
                    irqpnd_pkg::KEYCLR_OFFSET: prdata <= {28'h0, ktEdge_q};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule : irqpnd_top

//--- verif/irqpnd_levels.svh
// priority level of each pending bit and the highest level in a set of bits
function automatic logic [2:0] lvlOf(input int b);
    case (b)
        23: return 3'h7;
        22, 19, 7, 1: return 3'h6;
        20: return 3'h5;
        18: return 3'h3;
        17: return 3'h2;
        16: return 3'h1;
        default: return 3'h4;
    endcase
endfunction : lvlOf
// highest level among the set bits, zero when none is set
function automatic logic [2:0] maxLvl(input logic [31:0] p);
    logic [2:0] m;
    m = 3'h0;
    for (int b = 0; b < 32; b++)
        if (p[b] && lvlOf(b) > m)
            m = lvlOf(b);
    return m;
endfunction : maxLvl

//--- verif/irqpnd_props.sv
// assertions on the ports of the pending-flag block
`timescale 1ns/1ps
module irqpnd_props
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic emuBreak0,
    input wire logic emuBreak1,
    input wire logic externalEmulatorRequestN,
    input wire logic externalRequestPin1N,
    input wire logic externalRequestPin2N,
    input wire logic externalRequestPin3N,
    input wire logic externalRequestPin6N,
    input wire logic [3:0] keyboardTypeInputN,
    input wire logic [2:0] priorityLevel,
    input wire logic wakeCore,
    input wire logic [31:0] pendingFlags
);
    `include "irqpnd_levels.svh"
    // high while any of the eight key lines is pulled low
    logic keyAny;
    assign keyAny = ~&{keyboardTypeInputN, externalRequestPin1N, externalRequestPin2N,
        externalRequestPin3N, externalRequestPin6N};
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready missing after setup");
    property p_single;
        pready |=> !pready;
    endproperty
    a_single: assert property (p_single)
        else $error("ready held too long");
    property p_refuse;
        psel && !penable && paddr > 12'h014 |=> pslverr && prdata == 32'h00000000;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("unmapped access not refused");
    property p_reserved;
        (pendingFlags & 32'hFF20F020) == 32'h00000000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved pending bit set");
    property p_emu;
        emuBreak0 || emuBreak1 || $fell(externalEmulatorRequestN) |-> ##[1:3] pendingFlags[23];
    endproperty
    a_emu: assert property (p_emu)
        else $error("emulator request not flagged");
    property p_wake;
        wakeCore == $past(keyAny);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake does not follow key lines");
    property p_bound;
        $stable(pendingFlags) [*3] |-> priorityLevel <= maxLvl(pendingFlags);
    endproperty
    a_bound: assert property (p_bound)
        else $error("level above every pending source");
    property p_top;
        priorityLevel == 3'h7 |-> $past(pendingFlags[23]) || $past(pendingFlags[23], 2);
    endproperty
    a_top: assert property (p_top)
        else $error("level seven without emulator flag");
    // main scenarios reached
    c_refused: cover property (pslverr);
    c_emu: cover property (priorityLevel == 3'h7);
    c_wake: cover property ($rose(wakeCore));
endmodule : irqpnd_props
bind irqpnd_top irqpnd_props u_props (.*);

//--- verif/irqpnd_source_model.sv
// request sources: their lines change only just after a rising edge
`timescale 1ns/1ps
module irqpnd_source_model
(
    input wire logic clock,
    input wire logic [18:0] cmd,
    output logic [18:0] sourceLines_q
);
    // start at rest so no line is unknown at time zero
    initial sourceLines_q = 19'h101FF;
    // emulator line falls on command, level requests stay until removed at source
    always @(posedge clock)
        sourceLines_q <= cmd;
endmodule : irqpnd_source_model

//--- verif/test_interrupt_pending_sources.sv
// self-checking bench of the pending-flag block against a behavioural model
`timescale 1ns/1ps
module test_interrupt_pending_sources;
    localparam logic [18:0] IDLE = 19'h101FF; // all sources at rest
    logic clock = 1'b0; // 4 ns period
    logic sys_rst = 1'b1; // held for 12 cycles
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF; // whole words only
    logic [31:0] prdata, pendingFlags, r;
    logic pready, pslverr, wakeCore, e;
    logic [2:0] priorityLevel;
    logic emuBreak0, emuBreak1, externalEmulatorRequestN, samplingTimerEvent, pwmRollover;
    logic rtcRequest, watchdogRequest, uartRequest, timerEvent, serialDone, penRequestPin;
    logic externalRequestPin1N, externalRequestPin2N, externalRequestPin3N;
    logic externalRequestPin6N;
    logic [3:0] keyboardTypeInputN;
    logic [18:0] cmd = IDLE, lines; // commanded and driven source lines
    logic [31:0] mask = 32'hFFFFFFFF, ctrl = 32'h00000000; // model registers
    logic [4:0] pinL = 5'h00; // model edge latches of pins 1 2 3 5 6
    logic [3:0] ktL = 4'h0; // model keyboard-type latches
    logic [2:0] emuL = 3'h0; // model emulation status
    logic [11:0] addrOf [5] = '{irqpnd_pkg::MASK_OFFSET, irqpnd_pkg::PEND_OFFSET,
        irqpnd_pkg::EMUS_OFFSET, irqpnd_pkg::KEYCLR_OFFSET, irqpnd_pkg::STAT_OFFSET};
    int mismatches = 0, total_checks = 0, seed = 23;
    `include "irqpnd_levels.svh"
    // free-running clock
    always #2 clock = ~clock;
    // source lines split onto the block inputs
    assign {emuBreak0, emuBreak1, externalEmulatorRequestN, samplingTimerEvent, pwmRollover,
        rtcRequest, watchdogRequest, uartRequest, timerEvent, serialDone, externalRequestPin1N,
        externalRequestPin2N, externalRequestPin3N, externalRequestPin6N, penRequestPin,
        keyboardTypeInputN} = lines;
    irqpnd_source_model src (.clock(clock), .cmd(cmd), .sourceLines_q(lines));
    irqpnd_top uut (.*);
    // active request of pins 1 2 3 5 6 for a set of lines
    function automatic logic [4:0] act(input logic [18:0] c);
        return {~c[5], c[4] ~^ ctrl[12], ~c[6], ~c[7], ~c[8]};
    endfunction : act
    // pending view expected from the model state
    function automatic logic [31:0] expPend();
        logic [4:0] lv;
        logic [31:0] p;
        lv = (ctrl[4:0] & pinL) | (~ctrl[4:0] & act(cmd));
        p = 32'h00000000;
        p[23] = |emuL;
        p[22] = cmd[15];
        p[20:16] = {lv[3], lv[4], lv[2:0]};
        p[11:8] = (ctrl[11:8] & ktL) | (~ctrl[11:8] & ~cmd[3:0]);
        p[7] = cmd[14];
        p[6] = ~&{cmd[8:5], cmd[3:0]};
        p[4:0] = cmd[13:9];
        return p;
    endfunction : expPend
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // counts, verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    // new source lines, noting which edges the block must latch
    task automatic drive(input logic [18:0] nc);
        pinL = pinL | (act(nc) & ~act(cmd) & ctrl[4:0]);
        ktL = ktL | (~nc[3:0] & cmd[3:0] & ctrl[11:8]);
        emuL = emuL | {cmd[16] & ~nc[16], nc[17], nc[18]};
        @(posedge clock);
        cmd <= nc;
    endtask : drive
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        for (int n = 0; n < 16 && pready !== 1'b1; n++)
            @(posedge clock);
        if (pready !== 1'b1)
        begin
            mismatches++;
            report_and_stop();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // let sources settle, then compare every view with the model
    task automatic check_all();
        logic [31:0] p;
        p = expPend();
        repeat (4) @(posedge clock);
        chk(pendingFlags, p);
        chk(32'(priorityLevel), 32'(maxLvl(p & ~mask)));
        chk(32'(wakeCore), 32'(p[6]));
        apb(1'b0, 12'h000, 32'h00000000);
        chk(r, p);
        apb(1'b0, 12'h008, 32'h00000000);
        chk(r, p & ~mask);
        apb(1'b0, 12'h010, 32'h00000000);
        chk(r, 32'(emuL));
    endtask : check_all
    // random source change and random register write
    task automatic step();
        logic [31:0] d;
        logic [18:0] s;
        int op;
        d = $random(seed);
        s = d[18:0];
        drive(s);
        op = {$random(seed)} % 5;
        d = $random(seed);
        case (op)
            0: mask = d;
            1: d = d & 32'h00DF0FDF;
            2: emuL = (emuL & ~d[2:0]) | {1'b0, s[17], s[18]};
            3: ktL = ktL & ~d[3:0];
            default: ;
        endcase
        if (op == 1)
            pinL = pinL & ~{d[19], d[20], d[18:16]};
        apb(1'b1, addrOf[op], d);
        check_all();
    endtask : step
    // main sequence
    initial
    begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        // reset values and a refused slot
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, 12'(4 * i), 32'h00000000);
            chk(r, (i == 1) ? irqpnd_pkg::MASK_RESET : irqpnd_pkg::ZERO32);
            chk(32'(e), 32'(i == 6));
        end
        apb(1'b1, 12'h018, 32'hFFFFFFFF);
        chk(32'(e), 32'h00000001);
        $display("reset test done");
        repeat (40) step();
        $display("level test done");
        drive(IDLE);
        apb(1'b1, irqpnd_pkg::CTRL_OFFSET, 32'hFFFFFFFF);
        apb(1'b0, irqpnd_pkg::CTRL_OFFSET, 32'h00000000);
        chk(r, irqpnd_pkg::CTRL_WMASK);
        ctrl = irqpnd_pkg::CTRL_WMASK;
        drive(IDLE & ~19'h00010);
        apb(1'b1, 12'h000, 32'h001F0000);
        apb(1'b1, 12'h014, 32'h0000000F);
        apb(1'b1, 12'h010, 32'h00000007);
        pinL = 5'h00;
        ktL = 4'h0;
        emuL = 3'h0;
        repeat (40) step();
        $display("edge test done");
        report_and_stop();
    end
endmodule : test_interrupt_pending_sources
